// *** include/wbed_pkg.sv ***
// Package for the wired bus and edge decoder block
package wbed_pkg;

  // Buffer cell modes
  typedef enum logic [1:0] {
    WBED_MODE_STD    = 2'h0,
    WBED_MODE_WAND   = 2'h1,
    WBED_MODE_WORAND = 2'h2,
    WBED_MODE_OFF    = 2'h3
  } wbed_mode_t;

  // Keeper reset level before any driver is seen
  localparam logic WBED_KEEP_RST = 1'h1;

  // Decoder polarity field codes
  localparam logic WBED_POL_TRUE = 1'h0;
  localparam logic WBED_POL_COMP = 1'h1;

  // Decoder layout defaults
  localparam int WBED_EDGES        = 4;
  localparam int WBED_DEC_PER_EDGE = 4;
  localparam int WBED_VARS_PER_RC  = 3;
  localparam int WBED_DEC_MIN_IN   = 42;
  localparam int WBED_DEC_MAX_IN   = 132;

  // Per-cell drive request carried as one bundle
  typedef struct packed {
    wbed_mode_t mode;
    logic       data_a;
    logic       data_b;
    logic       hiz;
  } wbed_cell_t;

  // Resolved drive of one cell onto a line
  typedef struct packed {
    logic drv_en;
    logic drv_val;
  } wbed_drive_t;

endpackage : wbed_pkg

// *** rtl/wbed_top.sv ***
// Wired longline bus fabric with keepers and wide edge decoders
// Functional notes
// (RQ1) A buffer floats its output when its hi-Z control is 1 and drives its input when it is 0.
// (RQ2) User logic holds the hi-Z control low to get a plain always-driving buffer.
// (RQ3) In wired-AND mode the hi-Z control follows the data input, so only a low input pulls the line.
// (RQ4) In wired OR-AND mode either high input releases the line and only both low pulls it low.
// (RQ5) A wired-AND line reads high through its pull-up only when every connected input is high.
// (RQ6) A longline mux passes the data of the buffer whose hi-Z control is low.
// (RQ7) Each longline has a weak keeper holding its last level when undriven; any driver overrides it.
// (RQ8) Two buffers per logic block drive the lines above and below, plus one per left or right edge I/O.
// (RQ9) Each edge decoder outputs high when the AND of its selected true or complemented inputs holds.
// (RQ10) Decoder inputs are edge pad inputs plus up to three variables from each row or column.
// (RQ11) Four decoders sit on each edge and each may split in two, up to 32 in all.
// (RQ12) Decoder width scales with array size, from 42 to 132 inputs.
// (RQ13) Decoder outputs feed logic-block inputs and may also go straight to output pads; a split decoder's high half has no pad route.
// (RQ14) User logic enables at most one buffer per longline in mux use.
`timescale 1ns/1ps
`default_nettype none

module wbed_top
  import wbed_pkg::*;
#(
  parameter int ROWS    = 4,
  parameter int COLS    = 4,
  parameter int DEC_IN  = WBED_DEC_MIN_IN,
  parameter int PADS    = DEC_IN - COLS * WBED_VARS_PER_RC
) (
  // Clock and reset, used only by the line keepers
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  // Logic-block buffer pairs: index [row][col][0=up,1=down]
  input  wire wbed_cell_t                clb_cell_i  [ROWS][COLS][2],
  // Edge I/O buffers: [row][0=left,1=right]
  input  wire wbed_cell_t                io_cell_i   [ROWS][2],
  // Resolved horizontal longlines, ROWS+1 of them
  output logic                [ROWS:0]   line_o,
  output logic                [ROWS:0]   line_conflict_o,
  // Edge decoders: pad inputs and row/column variables per edge
  input  wire logic [WBED_EDGES-1:0][PADS-1:0]                      dec_pad_i,
  input  wire logic [WBED_EDGES-1:0][COLS*WBED_VARS_PER_RC-1:0]     dec_rc_i,
  // Per decoder: input use mask, polarity, split select
  input  wire logic [WBED_EDGES*WBED_DEC_PER_EDGE-1:0][DEC_IN-1:0] dec_use_i,
  input  wire logic [WBED_EDGES*WBED_DEC_PER_EDGE-1:0][DEC_IN-1:0] dec_pol_i,
  input  wire logic [WBED_EDGES*WBED_DEC_PER_EDGE-1:0]             dec_split_i,
  // Decoder outputs: two halves each to logic blocks, the low half also to a pad
  output logic [2*WBED_EDGES*WBED_DEC_PER_EDGE-1:0]                 dec_out_o,
  output logic [WBED_EDGES*WBED_DEC_PER_EDGE-1:0]                   dec_pad_out_o
);

  localparam int NDEC = WBED_EDGES * WBED_DEC_PER_EDGE;
  localparam int HALF = DEC_IN / 2;

  // Resolve one cell into an enable and a value
  function automatic wbed_drive_t cell_drive(input wbed_cell_t c);
    wbed_drive_t d;
    d = '0;
    case (c.mode)
      // (RQ1) Active-high hi-Z control
      WBED_MODE_STD: begin
        d.drv_en  = ~c.hiz;
        d.drv_val = c.data_a;
      end
      // (RQ3) Hi-Z tied to data
      WBED_MODE_WAND: begin
        d.drv_en  = ~c.data_a;
        d.drv_val = 1'h0;
      end
      // (RQ4) Open-drain OR gate
      WBED_MODE_WORAND: begin
        d.drv_en  = ~(c.data_a | c.data_b);
        d.drv_val = 1'h0;
      end
      default: begin
        d = '0;
      end
    endcase
    return d;
  endfunction : cell_drive

  // Polarity-applied AND over a masked input slice
  function automatic logic and_term(input logic [DEC_IN-1:0] v, input logic [DEC_IN-1:0] use_m,
                                    input logic [DEC_IN-1:0] pol);
    logic r;
    r = 1'h1;
    for (int k = 0; k < DEC_IN; k++) begin
      if (use_m[k] && ((v[k] ^ (pol[k] == WBED_POL_COMP)) == 1'h0)) begin
        r = 1'h0;
      end
    end
    return r;
  endfunction : and_term

  // Open-drain cells bring their line's pull-up with them
  function automatic logic is_open_drain(input wbed_cell_t c);
    return (c.mode == WBED_MODE_WAND) || (c.mode == WBED_MODE_WORAND);
  endfunction : is_open_drain

  // Line state: keepers and resolved drive
  logic [ROWS:0] keep_r;
  logic [ROWS:0] keep_nxt;
  logic [ROWS:0] any_en;
  logic [ROWS:0] any_hi;
  logic [ROWS:0] any_lo;
  logic [ROWS:0] any_pu;

  // Gather drivers onto each line; row r drives line r (above) and r+1 (below)
  always_comb begin
    wbed_drive_t d;
    d      = '0;
    any_en = '0;
    any_hi = '0;
    any_lo = '0;
    any_pu = '0;
    for (int r = 0; r < ROWS; r++) begin
      // (RQ8) Two cells per logic block
      for (int c = 0; c < COLS; c++) begin
        for (int s = 0; s < 2; s++) begin
          d = cell_drive(clb_cell_i[r][c][s]);
          // (RQ5) Pull-up joins with open-drain use
          if (is_open_drain(clb_cell_i[r][c][s])) any_pu[r+s] = 1'h1;
          if (d.drv_en) begin
            any_en[r+s] = 1'h1;
            if (d.drv_val) any_hi[r+s] = 1'h1;
            else           any_lo[r+s] = 1'h1;
          end
        end
      end
      // (RQ8) Edge I/O cells on the line above
      for (int s = 0; s < 2; s++) begin
        d = cell_drive(io_cell_i[r][s]);
        if (is_open_drain(io_cell_i[r][s])) any_pu[r] = 1'h1;
        if (d.drv_en) begin
          any_en[r] = 1'h1;
          if (d.drv_val) any_hi[r] = 1'h1;
          else           any_lo[r] = 1'h1;
        end
      end
    end
  end

  // (RQ5) Low wins; then a high driver, then pull-up, then keeper
  always_comb begin
    for (int l = 0; l <= ROWS; l++) begin
      if (any_lo[l])      line_o[l] = 1'h0;
      else if (any_hi[l]) line_o[l] = 1'h1;
      // (RQ7) Pull-up beats the keeper, so a released wired line reads high
      else if (any_pu[l]) line_o[l] = 1'h1;
      else                line_o[l] = keep_r[l];
    end
    // (RQ6) Mux selected by hi-Z controls; contention flagged
    line_conflict_o = any_lo & any_hi;
    // (RQ7) Keeper follows any driver
    keep_nxt = line_o;
  end

  // (RQ7) Weak keeper storage; it never overrides a driver
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      keep_r <= {(ROWS+1){WBED_KEEP_RST}};
    end else begin
      keep_r <= keep_nxt;
    end
  end

  // Edge decoders: assemble inputs, AND full or split halves
  always_comb begin
    logic [DEC_IN-1:0] v;
    logic [DEC_IN-1:0] lo_m;
    logic              full;
    v    = '0;
    lo_m = '0;
    full = 1'h0;
    for (int i = 0; i < HALF; i++) lo_m[i] = 1'h1;
    for (int n = 0; n < NDEC; n++) begin
      // (RQ10) Pads plus three vars per row or column
      v = {dec_rc_i[n / WBED_DEC_PER_EDGE], dec_pad_i[n / WBED_DEC_PER_EDGE]};
      // (RQ9) Wired-AND product term
      full = and_term(v, dec_use_i[n], dec_pol_i[n]);
      // (RQ11) Split into two narrower decoders
      if (dec_split_i[n]) begin
        dec_out_o[2*n]   = and_term(v, dec_use_i[n] & lo_m, dec_pol_i[n]);
        dec_out_o[2*n+1] = and_term(v, dec_use_i[n] & ~lo_m, dec_pol_i[n]);
      end else begin
        dec_out_o[2*n]   = full;
        dec_out_o[2*n+1] = full;
      end
      // (RQ13) Straight route to an output pad
      dec_pad_out_o[n] = dec_out_o[2*n];
    end
  end

  // (RQ12) Width within the documented range
  initial begin
    if (DEC_IN < WBED_DEC_MIN_IN || DEC_IN > WBED_DEC_MAX_IN) begin
      $error("decoder width out of range");
    end
  end

  // Undriven line holds its last level
  property p_keep_hold;
    @(posedge core_clk_i) disable iff (rst_i)
      (any_en == '0 && any_pu == '0) |=> ((any_en != '0) || (any_pu != '0) || (line_o == $past(line_o)));
  endproperty
  a_keep_hold: assert property (p_keep_hold) else $error("keeper lost level"); // RQ7

  // A low driver always wins the line
  property p_low_wins;
    @(posedge core_clk_i) disable iff (rst_i)
      (any_lo[0]) |-> (line_o[0] == 1'h0);
  endproperty
  a_low_wins: assert property (p_low_wins) else $error("line not pulled low"); // RQ5

  // Standard buffer with hi-Z low drives its value
  property p_std_drive;
    @(posedge core_clk_i) disable iff (rst_i)
      (clb_cell_i[0][0][0].mode == WBED_MODE_STD && !clb_cell_i[0][0][0].hiz)
        |-> (line_o[0] == clb_cell_i[0][0][0].data_a) || line_conflict_o[0];
  endproperty
  a_std_drive: assert property (p_std_drive) else $error("standard buffer not driving"); // RQ1

  // Wired OR-AND pulls low when both inputs are low
  property p_worand;
    @(posedge core_clk_i) disable iff (rst_i)
      (clb_cell_i[1][0][1].mode == WBED_MODE_WORAND && !clb_cell_i[1][0][1].data_a
        && !clb_cell_i[1][0][1].data_b) |-> (line_o[2] == 1'h0);
  endproperty
  a_worand: assert property (p_worand) else $error("or-and cell failed to pull"); // RQ4

  // Wired-AND low input pulls low
  property p_wand;
    @(posedge core_clk_i) disable iff (rst_i)
      (clb_cell_i[0][0][1].mode == WBED_MODE_WAND && !clb_cell_i[0][0][1].data_a) |-> !line_o[1];
  endproperty
  a_wand: assert property (p_wand) else $error("and cell failed to pull"); // RQ3

  // Unsplit decoder halves agree and reach the pad
  property p_dec_pad;
    @(posedge core_clk_i) disable iff (rst_i)
      !dec_split_i[0] |-> (dec_out_o[0] == dec_out_o[1]) && (dec_pad_out_o[0] == dec_out_o[0]);
  endproperty
  a_dec_pad: assert property (p_dec_pad) else $error("decoder output mismatch"); // RQ13

  // Empty mask decodes true
  property p_dec_empty;
    @(posedge core_clk_i) disable iff (rst_i)
      (dec_use_i[0] == '0) |-> dec_out_o[0];
  endproperty
  a_dec_empty: assert property (p_dec_empty) else $error("empty decoder not high"); // RQ9

  // One false input, after polarity, forces a full decoder low
  property p_dec_low;
    @(posedge core_clk_i) disable iff (rst_i)
      (!dec_split_i[0] && dec_use_i[0][0] && ((dec_pad_i[0][0] ^ dec_pol_i[0][0]) == 1'h0))
        |-> !dec_out_o[0];
  endproperty
  a_dec_low: assert property (p_dec_low) else $error("decoder high with false input"); // RQ9

  // Released wired-AND line rises through its pull-up
  property p_pullup;
    @(posedge core_clk_i) disable iff (rst_i)
      (clb_cell_i[0][0][1].mode == WBED_MODE_WAND && clb_cell_i[0][0][1].data_a && !any_lo[1]) |-> line_o[1];
  endproperty
  a_pullup: assert property (p_pullup) else $error("wired-and line not pulled up"); // RQ5

  // Wired OR-AND releases for any high input
  property p_worand_rel;
    @(posedge core_clk_i) disable iff (rst_i)
      (clb_cell_i[1][0][1].mode == WBED_MODE_WORAND && (clb_cell_i[1][0][1].data_a || clb_cell_i[1][0][1].data_b)
        && !any_lo[2]) |-> line_o[2];
  endproperty
  a_worand_rel: assert property (p_worand_rel) else $error("or-and cell failed to release"); // RQ4

  // Mux output follows the enabled edge buffer
  property p_mux_sel;
    @(posedge core_clk_i) disable iff (rst_i)
      (io_cell_i[0][0].mode == WBED_MODE_STD && !io_cell_i[0][0].hiz && !line_conflict_o[0])
        |-> (line_o[0] == io_cell_i[0][0].data_a);
  endproperty
  a_mux_sel: assert property (p_mux_sel) else $error("mux line not following selected buffer"); // RQ6

  // A line left undriven keeps the level it had at the edge
  property p_keep_load;
    @(posedge core_clk_i) disable iff (rst_i)
      (any_en[0] && !any_pu[0]) ##1 (!any_en[0] && !any_pu[0]) |-> (line_o[0] == $past(line_o[0]));
  endproperty
  a_keep_load: assert property (p_keep_load) else $error("keeper did not load the driven level"); // RQ7

  // A false input in the low half clears the low decoder
  property p_dec_split_lo;
    @(posedge core_clk_i) disable iff (rst_i)
      (dec_split_i[0] && dec_use_i[0][0] && ((dec_pad_i[0][0] ^ dec_pol_i[0][0]) == 1'h0)) |-> !dec_out_o[0];
  endproperty
  a_dec_split_lo: assert property (p_dec_split_lo) else $error("split low half high with false input"); // RQ11

  // Main scenarios
  c_conflict: cover property (@(posedge core_clk_i) disable iff (rst_i) line_conflict_o[2]);
  c_float:    cover property (@(posedge core_clk_i) disable iff (rst_i) any_en[0] ##1 !any_en[0]);
  c_split:    cover property (@(posedge core_clk_i) disable iff (rst_i) dec_split_i[0] && dec_out_o[0]);
  c_pullup:   cover property (@(posedge core_clk_i) disable iff (rst_i) !line_o[1] ##1 (line_o[1] && !any_en[1]));
  c_mux_sel:  cover property (@(posedge core_clk_i) disable iff (rst_i) !io_cell_i[0][0].hiz && !line_o[0]);

endmodule : wbed_top

`default_nettype wire

// *** verification/wbed_clb_model.sv ***
// Behavioural logic-block array that drives the longline buffer cells
`timescale 1ns/1ps
`default_nettype none
module wbed_clb_model
  import wbed_pkg::*;
#(
  parameter int ROWS = 4,
  parameter int COLS = 4
) (
  // Clock
  input  wire logic       core_clk_i,
  // Cell requests toward the fabric
  output var  wbed_cell_t clb_cell_o [ROWS][COLS][2],
  output var  wbed_cell_t io_cell_o  [ROWS][2]
);
  // park every cell, so one enabled driver selects the line
  task automatic release_all(input wbed_mode_t m, input logic a, input logic h);
    for (int r = 0; r < ROWS; r++) begin
      io_cell_o[r] <= '{'{m, a, a, h}, '{m, a, a, h}};
      for (int c = 0; c < COLS; c++) begin
        clb_cell_o[r][c] <= '{'{m, a, a, h}, '{m, a, a, h}};
      end
    end
  endtask : release_all

  // caller holds hiz low for a plain driver
  task automatic set_clb(input int r, c, k, input wbed_mode_t m, input logic a, b, h);
    clb_cell_o[r][c][k] <= '{m, a, b, h};
  endtask : set_clb

  task automatic set_io(input int r, s, input wbed_mode_t m, input logic a, h);
    io_cell_o[r][s] <= '{m, a, a, h};
  endtask : set_io

  // Nothing drives until the bench asks
  initial release_all(WBED_MODE_OFF, 1'h1, 1'h1);
endmodule : wbed_clb_model
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking testbench for the wired bus and edge decoder block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import wbed_pkg::*;
  localparam int ROWS = 4;
  localparam int COLS = 4;
  localparam int DEC_IN = WBED_DEC_MIN_IN;
  localparam int PADS = DEC_IN - COLS * WBED_VARS_PER_RC;
  localparam int NDEC = WBED_EDGES * WBED_DEC_PER_EDGE;
  logic                                             core_clk_i;
  logic                                             rst_i;
  wbed_cell_t                                       clb_cell [ROWS][COLS][2];
  wbed_cell_t                                       io_cell [ROWS][2];
  logic [ROWS:0]                                    line;
  logic [ROWS:0]                                    conflict;
  logic [WBED_EDGES-1:0][PADS-1:0]                  dec_pad;
  logic [WBED_EDGES-1:0][COLS*WBED_VARS_PER_RC-1:0] dec_rc;
  logic [NDEC-1:0][DEC_IN-1:0]                      dec_use;
  logic [NDEC-1:0][DEC_IN-1:0]                      dec_pol;
  logic [NDEC-1:0]                                  dec_split;
  logic [2*NDEC-1:0]                                dec_out;
  logic [NDEC-1:0]                                  dec_pad_out;
  int                                               n_fail;
  int                                               total_checks;

  wbed_clb_model #(.ROWS(ROWS), .COLS(COLS)) pm (.core_clk_i(core_clk_i), .clb_cell_o(clb_cell), .io_cell_o(io_cell));
  wbed_top #(.ROWS(ROWS), .COLS(COLS), .DEC_IN(DEC_IN)) DUT (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .clb_cell_i(clb_cell), .io_cell_i(io_cell), .line_o(line),
    .line_conflict_o(conflict), .dec_pad_i(dec_pad), .dec_rc_i(dec_rc), .dec_use_i(dec_use), .dec_pol_i(dec_pol),
    .dec_split_i(dec_split), .dec_out_o(dec_out), .dec_pad_out_o(dec_pad_out));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
      n_fail++;
    end
  endtask : check

  task automatic final_report();
    $display("Checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // Drive one cell, hold it, then release it and watch the keeper
  task automatic t_std_keeper();
    for (int d = 0; d < 2; d++) begin
      @(posedge core_clk_i);
      pm.set_clb(0, 0, 0, WBED_MODE_STD, d[0], d[0], 1'h0);
      #1 check("std_drive", d[0], line[0]);
      @(posedge core_clk_i);
      pm.set_clb(0, 0, 0, WBED_MODE_STD, ~d[0], ~d[0], 1'h1);
      repeat (3) @(posedge core_clk_i);
      #1 check("keeper_hold", d[0], line[0]);
    end
  endtask : t_std_keeper

  // Open-drain cells ignore their hiz pin, so a high input never fights
  task automatic t_wand();
    for (int p = 0; p < 16; p++) begin
      @(posedge core_clk_i);
      for (int c = 0; c < COLS; c++) pm.set_clb(0, c, 1, WBED_MODE_WAND, p[c], p[c], 1'h0);
      #1 check("wand_line", &p[3:0], line[1]);
      check("wand_conflict", 1'h0, conflict[1]);
    end
  endtask : t_wand

  task automatic t_worand();
    for (int p = 0; p < 4; p++) begin
      @(posedge core_clk_i);
      pm.set_clb(1, 0, 1, WBED_MODE_WORAND, p[0], p[1], 1'h0);
      #1 check("worand_line", |p[1:0], line[2]);
    end
  endtask : t_worand

  // Every source on every line, with parked rivals holding opposite data
  task automatic t_mux_map();
    int t;
    for (int r = 0; r < ROWS; r++) for (int s = 0; s < 2 * COLS + 2; s++) for (int d = 0; d < 2; d++) begin
      t = (s < 2) ? r : r + (s - 2) / COLS;
      @(posedge core_clk_i);
      pm.release_all(WBED_MODE_STD, ~d[0], 1'h1);
      @(posedge core_clk_i);
      if (s < 2) pm.set_io(r, s, WBED_MODE_STD, d[0], 1'h0);
      else pm.set_clb(r, (s - 2) % COLS, (s - 2) / COLS, WBED_MODE_STD, d[0], d[0], 1'h0);
      #1 check("mux_line", d[0], line[t]);
    end
  endtask : t_mux_map

  task automatic t_conflict_off();
    @(posedge core_clk_i);
    pm.set_clb(2, 0, 0, WBED_MODE_STD, 1'h1, 1'h1, 1'h0);
    pm.set_io(2, 0, WBED_MODE_STD, 1'h0, 1'h0);
    pm.set_clb(3, 0, 0, WBED_MODE_STD, 1'h1, 1'h1, 1'h0);
    #1 check("contend", 2'h2, {conflict[2], line[2]});
    @(posedge core_clk_i);
    pm.release_all(WBED_MODE_OFF, 1'h0, 1'h0);
    repeat (2) @(posedge core_clk_i);
    #1 check("off_mode", 1'h1, line[3]);
  endtask : t_conflict_off

  // Bits are {hi half, lo half, pad copy} of one decoder
  task automatic t_decode();
    logic [DEC_IN-1:0] v;
    int e;
    for (int n = 0; n < NDEC; n++) begin
      e = n / WBED_DEC_PER_EDGE;
      v = ~{dec_rc[e], dec_pad[e]};
      @(posedge core_clk_i);
      dec_use[n] <= '1;
      dec_pol[n] <= v;
      #1 check("dec_full", 3'h7, {dec_out[2*n+1], dec_out[2*n], dec_pad_out[n]});
      @(posedge core_clk_i);
      dec_pol[n] <= v ^ (DEC_IN'(1) << n);
      #1 check("dec_miss", 3'h0, {dec_out[2*n+1], dec_out[2*n], dec_pad_out[n]});
      @(posedge core_clk_i);
      dec_split[n] <= 1'h1;
      #1 check("dec_split_lo", 3'h4, {dec_out[2*n+1], dec_out[2*n], dec_pad_out[n]});
      @(posedge core_clk_i);
      dec_pol[n] <= v ^ (DEC_IN'(1) << (DEC_IN - 1 - n));
      #1 check("dec_split_hi", 3'h3, {dec_out[2*n+1], dec_out[2*n], dec_pad_out[n]});
    end
  endtask : t_decode

  initial begin
    core_clk_i = 1'h0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  initial begin
    #200000;
    n_fail++;
    $display("ERROR watchdog expected 0 seen 1");
    final_report();
  end

  initial begin
    rst_i = 1'h1;
    n_fail = 0;
    total_checks = 0;
    dec_use = '0;
    dec_pol = '0;
    dec_split = '0;
    for (int e = 0; e < WBED_EDGES; e++) begin
      dec_pad[e] = PADS'(64'h9E37_79B9_7F4A_7C15 >> e);
      dec_rc[e] = 12'hA5C ^ 12'(e);
    end
    @(posedge core_clk_i);
    #1 check("reset_lines", 5'h1F, line);
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'h0;
    t_std_keeper();
    t_wand();
    t_worand();
    t_mux_map();
    t_conflict_off();
    t_decode();
    final_report();
  end
endmodule : testbench
`default_nettype wire
